/* hdl/dipc_consts.vh */
// Constants for the dual-issue pairing check
`ifndef DIPC_CONSTS_VH
`define DIPC_CONSTS_VH
// Instruction class codes presented by decode
`define DIPC_CLS_W        5
`define DIPC_CLS_OTHER    5'h00
`define DIPC_CLS_NOP      5'h01
`define DIPC_CLS_MOV      5'h02
`define DIPC_CLS_NOT      5'h03
`define DIPC_CLS_SLD      5'h04
`define DIPC_CLS_SST      5'h05
`define DIPC_CLS_SAT      5'h06
`define DIPC_CLS_MULH     5'h07
`define DIPC_CLS_LOGIC    5'h08
`define DIPC_CLS_TST      5'h09
`define DIPC_CLS_SUB      5'h0a
`define DIPC_CLS_ADD      5'h0b
`define DIPC_CLS_CMP      5'h0c
`define DIPC_CLS_SHIFT    5'h0d
`define DIPC_CLS_EXT      5'h0e
`define DIPC_CLS_UBR      5'h0f
`define DIPC_CLS_BCC      5'h10
// Issue decision codes
`define DIPC_DEC_W        2
`define DIPC_DEC_SINGLE   2'h0
`define DIPC_DEC_FUSED    2'h1
`define DIPC_DEC_PARALLEL 2'h2
// Reset values
`define DIPC_RST_DEC      2'h0
`define DIPC_RST_FLAGS    2'h0
`endif

/* hdl/dipc_pair_check.v */
// Issue pairing decision logic for a dual-issue pipeline
`timescale 1ns/1ps
`default_nettype none
`include "dipc_consts.vh"

module dipc_pair_check #(
  parameter REG_W = 5
)(
  input  wire                      core_clk,
  input  wire                      reset,
  input  wire                      slot_valid,
  input  wire [`DIPC_CLS_W-1:0]    first_class,
  input  wire [REG_W-1:0]          first_dst,
  input  wire                      first_flag_upd,
  input  wire                      first_unaligned_target,
  input  wire                      second_valid,
  input  wire [`DIPC_CLS_W-1:0]    second_class,
  input  wire [REG_W-1:0]          second_dst,
  input  wire                      second_fusable,
  input  wire                      ep_write_pending,
  input  wire                      load_buf0_wb_wait,
  input  wire                      load_buf1_wb_wait,
  output reg                       issue_valid,
  output reg  [`DIPC_DEC_W-1:0]    issue_kind,
  output reg                       consume_two
);

  // ----------------------------------------------------------------
  // Class set functions
  // ----------------------------------------------------------------
  // Shared arithmetic set used by unconditional-branch and short-load pairing
  function arith_set;
    input [`DIPC_CLS_W-1:0] c;
    begin
      case (c)
        `DIPC_CLS_NOP, `DIPC_CLS_MOV, `DIPC_CLS_NOT, `DIPC_CLS_SAT,
        `DIPC_CLS_MULH, `DIPC_CLS_LOGIC, `DIPC_CLS_TST, `DIPC_CLS_SUB,
        `DIPC_CLS_ADD, `DIPC_CLS_CMP, `DIPC_CLS_SHIFT:
          arith_set = 1'b1;
        default:
          arith_set = 1'b0;
      endcase
    end
  endfunction

  // Operations that may merge with a preceding move
  function fuse_set;
    input [`DIPC_CLS_W-1:0] c;
    begin
      case (c)
        `DIPC_CLS_SAT, `DIPC_CLS_MULH, `DIPC_CLS_LOGIC, `DIPC_CLS_SUB,
        `DIPC_CLS_ADD, `DIPC_CLS_SHIFT:
          fuse_set = 1'b1;
        default:
          fuse_set = 1'b0;
      endcase
    end
  endfunction

  // Non-flag instructions allowed ahead of a conditional branch
  function noflag_set;
    input [`DIPC_CLS_W-1:0] c;
    begin
      case (c)
        `DIPC_CLS_NOP, `DIPC_CLS_MOV, `DIPC_CLS_SLD, `DIPC_CLS_SST,
        `DIPC_CLS_MULH, `DIPC_CLS_EXT:
          noflag_set = 1'b1;
        default:
          noflag_set = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Flag-update history
  // ----------------------------------------------------------------
  // Flag updaters of the two most recently issued instructions
  reg  [1:0] flag_hist;
  wire       hazard;
  wire       hist_flag_last;

  // First instruction of a slot sets the newest history bit, or bit 1 when the pair issues in parallel
  assign hist_flag_last = first_flag_upd;

  // ----------------------------------------------------------------
  // Pair decision
  // ----------------------------------------------------------------
  reg                    next_fuse;
  reg                    next_par;
  reg                    both_wait;

  // A conditional branch in the later slot looks back at two
  // instructions: the first of the pair and the last one issued
  // before it. Either may have written the flags, and the branch
  // would then resolve on a stale condition if it went in parallel.
  // Short loads in the later slot depend instead on the pointer
  // register and the load buffers, both reported by writeback.
  // Fusion ignores these hazards: the fused pair is one operation
  // and runs through the normal single-issue interlocks.

  // flag hazard
  // First of the pair or the one before it may change flags
  assign hazard = first_flag_upd | flag_hist[0];

  always @*
  begin
    both_wait = load_buf0_wb_wait & load_buf1_wb_wait;
    next_fuse = 1'b0;
    next_par  = 1'b0;
    if (second_valid && first_class == `DIPC_CLS_MOV &&
        fuse_set(second_class) && second_fusable &&
        first_dst == second_dst && first_dst != {REG_W{1'b0}})
      next_fuse = 1'b1;
    if (second_valid)
    begin
      case (second_class)
        `DIPC_CLS_UBR:
          next_par = arith_set(first_class) ||
                     first_class == `DIPC_CLS_SLD ||
                     first_class == `DIPC_CLS_SST;
        `DIPC_CLS_BCC:
          next_par = noflag_set(first_class) && !hazard;
        `DIPC_CLS_SLD:
          next_par = arith_set(first_class) && !ep_write_pending &&
                     !both_wait;
        default:
          next_par = 1'b0;
      endcase
    end
    if (first_unaligned_target)
    begin
      next_fuse = 1'b0;
      next_par  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered issue outputs
  // ----------------------------------------------------------------
  // single issue fallback
  // Rejected pair issues first alone; second re-evaluated next slot
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      issue_valid <= 1'b0;
      issue_kind  <= `DIPC_RST_DEC;
      consume_two <= 1'b0;
    end
    else
    begin
      issue_valid <= slot_valid;
      if (slot_valid)
      begin
        if (next_fuse)
        begin
          issue_kind  <= `DIPC_DEC_FUSED;
          consume_two <= 1'b1;
        end
        else if (next_par)
        begin
          issue_kind  <= `DIPC_DEC_PARALLEL;
          consume_two <= 1'b1;
        end
        else
        begin
          issue_kind  <= `DIPC_DEC_SINGLE;
          consume_two <= 1'b0;
        end
      end
      else
      begin
        issue_kind  <= `DIPC_DEC_SINGLE;
        consume_two <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag-update history register
  // ----------------------------------------------------------------
  // Bit 0 is the last issued instruction, bit 1 the one before it.
  // A fused pair counts as a flag writer (conservative); a parallel
  // pair ends in a branch or short load, which never writes flags,
  // so its first instruction moves to the older position.
  always @(posedge core_clk)
  begin
    if (reset)
      flag_hist <= `DIPC_RST_FLAGS;
    else if (slot_valid)
    begin
      if (next_fuse)
        flag_hist <= 2'h1;
      else if (next_par)
        flag_hist <= {hist_flag_last, 1'b0};
      else
        flag_hist <= {flag_hist[0], hist_flag_last};
    end
  end

endmodule
`default_nettype wire

/* sim/dipc_exec_model.sv */
// Writeback side model: pointer write and load buffer waits
`timescale 1ns/1ps
`default_nettype none
module dipc_exec_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       ep_wr,
  input  wire logic [1:0] ld_go,
  output var  logic       ep_write_pending,
  output var  logic [1:0] buf_wait
);
  // Each write or load waits one cycle for writeback
  always @(posedge core_clk)
  begin
    ep_write_pending <= !reset && ep_wr;
    buf_wait         <= reset ? 2'h0 : ld_go;
  end
endmodule
`default_nettype wire

/* sim/dipc_pair_check_sva.sv */
// Checker for the pairing decision
`timescale 1ns/1ps
`default_nettype none
`include "dipc_consts.vh"
module dipc_pair_check_sva #(parameter REG_W = 5) (
  input wire logic core_clk, reset, slot_valid, first_flag_upd,
  input wire logic first_unaligned_target, second_valid, second_fusable,
  input wire logic ep_write_pending, load_buf0_wb_wait, load_buf1_wb_wait,
  input wire logic [`DIPC_CLS_W-1:0] first_class, second_class,
  input wire logic [REG_W-1:0]       first_dst, second_dst,
  input wire logic issue_valid, consume_two,
  input wire logic [`DIPC_DEC_W-1:0] issue_kind
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire sld2 = slot_valid && second_class == `DIPC_CLS_SLD;
  a_move_fused: assert property (slot_valid && second_valid && second_fusable
    && second_class inside {`DIPC_CLS_SAT, `DIPC_CLS_MULH, `DIPC_CLS_LOGIC,
    `DIPC_CLS_SUB, `DIPC_CLS_ADD, `DIPC_CLS_SHIFT}
    && first_class == `DIPC_CLS_MOV && first_dst == second_dst && first_dst != 0
    && !first_unaligned_target |=> issue_kind == `DIPC_DEC_FUSED) else $error("no fuse");
  a_fuse_order: assert property (issue_kind == `DIPC_DEC_FUSED |->
    $past(first_class) == `DIPC_CLS_MOV) else $error("bad fuse order");
  a_later_kind: assert property (issue_kind == `DIPC_DEC_PARALLEL |->
    $past(second_class) inside {`DIPC_CLS_UBR, `DIPC_CLS_BCC, `DIPC_CLS_SLD})
    else $error("bad later class");
  a_unaligned_alone: assert property (slot_valid && first_unaligned_target
    |=> !consume_two) else $error("unaligned paired");
  a_ptr_block: assert property (sld2 && ep_write_pending |=> !consume_two)
    else $error("pointer hazard paired");
  a_flag_block: assert property (slot_valid && first_flag_upd &&
    second_class == `DIPC_CLS_BCC |=> !consume_two) else $error("flag hazard");
  a_buf_block: assert property (sld2 && load_buf0_wb_wait && load_buf1_wb_wait
    |=> !consume_two) else $error("buffers full paired");
  a_single_one: assert property (slot_valid |=> issue_valid &&
    (consume_two == (issue_kind != `DIPC_DEC_SINGLE))) else $error("bad issue");
endmodule
`default_nettype wire

/* sim/test_dipc_pair_check.sv */
// Testbench for the pairing decision
`timescale 1ns/1ps
`default_nettype none
`include "dipc_consts.vh"
module test_dipc_pair_check;
  logic core_clk, reset, slot_valid, first_flag_upd, first_unaligned_target;
  logic second_valid, second_fusable, issue_valid, consume_two, ep_wr;
  logic [4:0] first_class, second_class, first_dst, second_dst;
  logic [1:0] issue_kind, ld_go, buf_wait;
  logic       ep_write_pending;
  int fails = 0, checks = 0;
  dipc_pair_check #(.REG_W(5)) i_dipc_pair_check (.*,
    .load_buf0_wb_wait(buf_wait[0]), .load_buf1_wb_wait(buf_wait[1]));
  dipc_exec_model i_dipc_exec_model (.*);
  initial
  begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  // One slot, decision checked one cycle later
  task slot(input logic [4:0] fc, sc, fd, sd, input logic [2:0] fl,
            input logic [3:0] exp);
    @(posedge core_clk);
    #1;
    {first_class, second_class, first_dst, second_dst} = {fc, sc, fd, sd};
    {first_flag_upd, first_unaligned_target, second_fusable} = fl;
    slot_valid = 1;
    @(posedge core_clk);
    #1;
    slot_valid = 0;
    checks++;
    if ({issue_valid, issue_kind, consume_two} !== exp)
    begin
      fails++;
      $display("CHECK FAILED issue exp %h seen %h", exp,
               {issue_valid, issue_kind, consume_two});
    end
  endtask
  task t_fuse;
    slot(`DIPC_CLS_MOV, `DIPC_CLS_ADD, 3, 3, 3'h1, 4'hb);
    slot(`DIPC_CLS_ADD, `DIPC_CLS_MOV, 3, 3, 3'h1, 4'h8);
    slot(`DIPC_CLS_MOV, `DIPC_CLS_ADD, 0, 0, 3'h1, 4'h8);
    slot(`DIPC_CLS_MOV, `DIPC_CLS_ADD, 3, 3, 3'h3, 4'h8);
  endtask
  task t_par;
    logic [16:0] ok [3];
    logic [4:0]  sc [3];
    ok = '{17'h03ffe, 17'h040b6, 17'h03fce};
    sc = '{`DIPC_CLS_UBR, `DIPC_CLS_BCC, `DIPC_CLS_SLD};
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 17; c++)
        slot(c[4:0], sc[k], 1, 2, 3'h0, ok[k][c] ? 4'hd : 4'h8);
    slot(`DIPC_CLS_NOP, `DIPC_CLS_ADD, 1, 2, 3'h1, 4'h8);
    second_valid = 0;
    slot(`DIPC_CLS_NOP, `DIPC_CLS_UBR, 1, 2, 3'h0, 4'h8);
    second_valid = 1;
  endtask
  task t_block;
    ep_wr = 1;
    slot(`DIPC_CLS_NOP, `DIPC_CLS_SLD, 1, 2, 3'h0, 4'h8);
    ep_wr = 0;
    slot(`DIPC_CLS_NOP, `DIPC_CLS_SLD, 1, 2, 3'h0, 4'hd);
    ld_go = 2'h3;
    slot(`DIPC_CLS_NOP, `DIPC_CLS_SLD, 1, 2, 3'h0, 4'h8);
    ld_go = 2'h1;
    slot(`DIPC_CLS_NOP, `DIPC_CLS_SLD, 1, 2, 3'h0, 4'hd);
    ld_go = 2'h0;
    slot(`DIPC_CLS_CMP, `DIPC_CLS_BCC, 1, 2, 3'h4, 4'h8);
    slot(`DIPC_CLS_CMP, `DIPC_CLS_OTHER, 1, 2, 3'h4, 4'h8);
    slot(`DIPC_CLS_NOP, `DIPC_CLS_BCC, 1, 2, 3'h0, 4'h8);
    slot(`DIPC_CLS_NOP, `DIPC_CLS_BCC, 1, 2, 3'h0, 4'hd);
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #4000;
    fails++;
    end_sim;
  end
  initial
  begin
    {reset, slot_valid, ep_wr, ld_go, second_valid} = 6'h21;
    {first_class, second_class, first_dst, second_dst} = 20'h0;
    {first_flag_upd, first_unaligned_target, second_fusable} = 3'h0;
    repeat (4) @(posedge core_clk);
    #1;
    reset = 0;
    t_fuse;
    t_par;
    t_block;
    end_sim;
  end
endmodule
bind dipc_pair_check dipc_pair_check_sva #(.REG_W(REG_W)) i_dipc_pair_check_sva (.*);
`default_nettype wire
